// ===== hw/sgl_pkg.sv
// package of constants and types for the start guard, edit lock and analog select block
// assumes a 100 MHz clock and a zero-wait-free apb slave that answers one cycle into access
package sgl_pkg;
	// clock rate and settle time after powerup before the run command is judged
	localparam int CLK_MHZ = 100;
	localparam int SETTLE_NS = 30;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	// advised wait for the operator before run, in milliseconds (far side only)
	localparam int GUARD_WAIT_MS = 3000;
	// apb register byte offsets
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] SLOT_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] INT_STAT_OFS = 8'h0C;
	localparam logic [7:0] INT_MASK_OFS = 8'h10;
	// configuration fields
	localparam int CFG_SCOPE_BIT = 0;
	localparam int CFG_LOCK_BIT = 1;
	localparam int CFG_SRC_LSB = 8;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [1:0] SRC_ANALOG = 2'h1;
	// input slot assignment: five slots of five bits each
	localparam int SLOTS = 5;
	localparam int FUNC_W = 5;
	localparam logic [24:0] SLOT_RST = 25'h000_0000;
	localparam logic [4:0] FN_GUARD = 5'h0D;
	localparam logic [4:0] FN_LOCK = 5'h0F;
	localparam logic [4:0] FN_ASEL = 5'h10;
	localparam logic [4:0] FN_RESET = 5'h12;
	// error codes shown while tripped
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_UV = 8'h09;
	localparam logic [7:0] ERR_GUARD = 8'h0D;
	// interrupt status bit positions
	localparam int INT_GUARD = 0;
	localparam int INT_UV = 1;
	localparam int INT_REFUSE = 2;
	localparam int INT_W = 3;
	// analog widths
	localparam int ADC_W = 10;
	localparam int FREQ_W = 11;
	// pin vector layout: run, undervoltage, keypad reset, five slots
	localparam int PIN_RUN = 0;
	localparam int PIN_UV = 1;
	localparam int PIN_KEY = 2;
	localparam int PIN_SLOT = 3;
	localparam int PIN_W = 8;
	// drive states
	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_STOP,
		ST_RUN,
		ST_GUARD_TRIP,
		ST_UV_TRIP,
		ST_RESET_HOLD
	} sgl_state_t;
endpackage : sgl_pkg

// ===== hw/sgl_top.sv
// start guard, parameter edit lock and analog source select for a motor drive
// assumes pins arrive asynchronously; analog words come from an adc on clk_in
`timescale 1ns/1ps
module sgl_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic run_cmd_in,
	input wire logic undervolt_in,
	input wire logic keypad_reset_in,
	input wire logic [4:0] slot_level_in,
	input wire logic edit_req_in,
	input wire logic edit_is_freq_in,
	input wire logic [9:0] volt_analog_in,
	input wire logic [9:0] current_analog_in,
	output logic drive_out,
	output logic trip_out,
	output logic [7:0] err_code_out,
	output logic edit_ack_out,
	output logic edit_refused_out,
	output logic [10:0] freq_cmd_out,
	output logic freq_valid_out,
	output logic irq_out
);
	////////////////////////////////////////////////////////////////////////////////
	// function decode helpers
	// true if any slot holding the code is on; all levels high asks only whether it is held
	function automatic logic fn_on(input logic [24:0] funcs, input logic [4:0] lvl,
			input logic [4:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < sgl_pkg::SLOTS; i++) begin
			if (funcs[i*sgl_pkg::FUNC_W +: sgl_pkg::FUNC_W] == code && lvl[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : fn_on
	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [7:0] pin_meta_reg; // first stage, read only by the second
	logic [7:0] pin_sync_reg; // settled pin levels
	logic key_prev_reg; // settled key level one cycle back, for the press edge
	logic [7:0] pin_raw;
	assign pin_raw = {slot_level_in, keypad_reset_in, undervolt_in, run_cmd_in};

	// two flops per pin
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_meta_reg <= 8'h00;
			pin_sync_reg <= 8'h00;
			key_prev_reg <= 1'b0; // key idles released, so no false press follows reset
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
			key_prev_reg <= pin_sync_reg[sgl_pkg::PIN_KEY];
		end
	end

	logic run_on; // run command level
	logic uv_on; // undervoltage level
	logic key_on; // keypad stop/reset level
	logic key_press; // one cycle on press
	logic [4:0] slot_lvl; // slot levels
	assign run_on = pin_sync_reg[sgl_pkg::PIN_RUN];
	assign uv_on = pin_sync_reg[sgl_pkg::PIN_UV];
	assign key_on = pin_sync_reg[sgl_pkg::PIN_KEY];
	assign slot_lvl = pin_sync_reg[sgl_pkg::PIN_SLOT +: sgl_pkg::SLOTS];
	assign key_press = key_on && !key_prev_reg;
	////////////////////////////////////////////////////////////////////////////////
	// apb slave and registers
	logic [31:0] cfg_reg; // scope, lock and source settings
	logic [24:0] slot_reg; // slot function codes
	logic [2:0] int_stat_reg; // sticky events
	logic [2:0] int_mask_reg; // event enables
	logic [2:0] int_set; // events this cycle
	logic acc; // access phase
	logic wr_en; // write taking effect
	logic [31:0] rd_mux; // read data
	logic rd_err; // unmapped address
	sgl_pkg::sgl_state_t state_reg;
	sgl_pkg::sgl_state_t state_next;
	assign acc = psel_in && penable_in;
	assign wr_en = acc && pwrite_in && pready_out && !pslverr_out;

	// address decode for reads and error
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr_in == sgl_pkg::CFG_OFS) begin
			rd_mux = cfg_reg;
		end else if (paddr_in == sgl_pkg::SLOT_OFS) begin
			rd_mux = {7'h00, slot_reg};
		end else if (paddr_in == sgl_pkg::STAT_OFS) begin
			rd_mux = {16'h0000, err_code_out, 5'h00, 3'(state_reg)};
		end else if (paddr_in == sgl_pkg::INT_STAT_OFS) begin
			rd_mux = {29'h0000_0000, int_stat_reg};
		end else if (paddr_in == sgl_pkg::INT_MASK_OFS) begin
			rd_mux = {29'h0000_0000, int_mask_reg};
		end else begin
			rd_err = 1'b1;
		end
	end

	// answer one cycle into the access phase
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end else begin
			pready_out <= acc && !pready_out;
			pslverr_out <= acc && !pready_out && rd_err;
			if (acc && !pready_out && !pwrite_in) begin
				prdata_out <= rd_mux;
			end
		end
	end

	// writable configuration
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cfg_reg <= sgl_pkg::CFG_RST;
			slot_reg <= sgl_pkg::SLOT_RST;
			int_mask_reg <= 3'h0;
		end else if (wr_en) begin
			if (paddr_in == sgl_pkg::CFG_OFS) begin
				cfg_reg <= pwdata_in;
			end else if (paddr_in == sgl_pkg::SLOT_OFS) begin
				slot_reg <= pwdata_in[24:0];
			end else if (paddr_in == sgl_pkg::INT_MASK_OFS) begin
				int_mask_reg <= pwdata_in[2:0];
			end
		end
	end

	// sticky events, a new event beats a write-one clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			int_stat_reg <= 3'h0;
		end else if (wr_en && paddr_in == sgl_pkg::INT_STAT_OFS) begin
			int_stat_reg <= (int_stat_reg & ~pwdata_in[2:0]) | int_set;
		end else begin
			int_stat_reg <= int_stat_reg | int_set;
		end
	end

	// level interrupt from unmasked events
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(int_stat_reg & int_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// live slot functions
	logic guard_on; // start guard enabled
	logic lock_in_on; // edit lock input on
	logic asel_set; // select function present
	logic asel_on; // current input chosen
	logic rs_on; // reset input held
	assign guard_on = fn_on(slot_reg, slot_lvl, sgl_pkg::FN_GUARD);
	assign lock_in_on = fn_on(slot_reg, slot_lvl, sgl_pkg::FN_LOCK);
	assign asel_set = fn_on(slot_reg, 5'h1F, sgl_pkg::FN_ASEL);
	assign asel_on = fn_on(slot_reg, slot_lvl, sgl_pkg::FN_ASEL);
	assign rs_on = fn_on(slot_reg, slot_lvl, sgl_pkg::FN_RESET);

	////////////////////////////////////////////////////////////////////////////////
	// drive state machine
	logic [1:0] settle_reg; // powerup settle count
	logic settled; // inputs judged
	logic from_guard_reg; // reset hold entered from guard trip
	assign settled = (settle_reg == 2'(sgl_pkg::SETTLE_CYC));
	// next state
	always_comb begin
		state_next = state_reg;
		if (rs_on) begin
			state_next = sgl_pkg::ST_RESET_HOLD;
		end else begin
			case (state_reg)
				sgl_pkg::ST_POWERUP: begin
					if (settled && run_on && guard_on) begin
						state_next = sgl_pkg::ST_GUARD_TRIP;
					end else if (settled && run_on) begin
						state_next = sgl_pkg::ST_RUN;
					end else if (settled) begin
						state_next = sgl_pkg::ST_STOP;
					end
				end
				sgl_pkg::ST_STOP: begin
					if (uv_on) begin
						state_next = sgl_pkg::ST_UV_TRIP;
					end else if (run_on) begin
						state_next = sgl_pkg::ST_RUN;
					end
				end
				sgl_pkg::ST_RUN: begin
					if (uv_on) begin
						state_next = sgl_pkg::ST_UV_TRIP;
					end else if (!run_on) begin
						state_next = sgl_pkg::ST_STOP;
					end
				end
				sgl_pkg::ST_GUARD_TRIP: begin
					if (!run_on) begin
						state_next = sgl_pkg::ST_STOP;
					end else if (key_press) begin
						state_next = sgl_pkg::ST_RUN;
					end
				end
				sgl_pkg::ST_UV_TRIP: begin
					if (key_press) begin
						state_next = sgl_pkg::ST_POWERUP;
					end
				end
				sgl_pkg::ST_RESET_HOLD: begin
					if (from_guard_reg && run_on) begin
						state_next = sgl_pkg::ST_RUN;
					end else if (from_guard_reg) begin
						state_next = sgl_pkg::ST_STOP;
					end else begin
						state_next = sgl_pkg::ST_POWERUP;
					end
				end
				default: begin
					state_next = sgl_pkg::ST_POWERUP;
				end
			endcase
		end
	end

	// state, settle count and outputs tied to the next state
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_reg <= sgl_pkg::ST_POWERUP;
			settle_reg <= 2'h0;
			from_guard_reg <= 1'b0;
			drive_out <= 1'b0;
			trip_out <= 1'b0;
			err_code_out <= sgl_pkg::ERR_NONE;
		end else begin
			state_reg <= state_next;
			settle_reg <= (state_reg == sgl_pkg::ST_POWERUP && !settled) ? settle_reg + 2'h1 : 2'h0;
			if (state_reg != sgl_pkg::ST_RESET_HOLD) begin
				from_guard_reg <= (state_reg == sgl_pkg::ST_GUARD_TRIP);
			end
			drive_out <= (state_next == sgl_pkg::ST_RUN);
			trip_out <= (state_next == sgl_pkg::ST_GUARD_TRIP) || (state_next == sgl_pkg::ST_UV_TRIP);
			if (state_next == sgl_pkg::ST_GUARD_TRIP) begin
				err_code_out <= sgl_pkg::ERR_GUARD;
			end else if (state_next == sgl_pkg::ST_UV_TRIP) begin
				err_code_out <= sgl_pkg::ERR_UV;
			end else begin
				err_code_out <= sgl_pkg::ERR_NONE;
			end
		end
	end
	assign int_set[sgl_pkg::INT_GUARD] = (state_next == sgl_pkg::ST_GUARD_TRIP) &&
		(state_reg != sgl_pkg::ST_GUARD_TRIP);
	assign int_set[sgl_pkg::INT_UV] = (state_next == sgl_pkg::ST_UV_TRIP) &&
		(state_reg != sgl_pkg::ST_UV_TRIP);
	////////////////////////////////////////////////////////////////////////////////
	// parameter edit lock
	logic lock_active; // lock by input or setting
	logic edit_block; // this request is refused
	assign lock_active = lock_in_on || cfg_reg[sgl_pkg::CFG_LOCK_BIT];
	// frequency stays editable unless the scope bit locks it too
	assign edit_block = lock_active && !(edit_is_freq_in && !cfg_reg[sgl_pkg::CFG_SCOPE_BIT]);
	assign int_set[sgl_pkg::INT_REFUSE] = edit_req_in && edit_block;

	// one cycle answer to each edit request
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			edit_ack_out <= 1'b0;
			edit_refused_out <= 1'b0;
		end else begin
			edit_ack_out <= edit_req_in && !edit_block;
			edit_refused_out <= edit_req_in && edit_block;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog frequency source
	// setpoint chosen by select input, or summed when no slot holds it
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			freq_cmd_out <= 11'h000;
			freq_valid_out <= 1'b0;
		end else if (cfg_reg[sgl_pkg::CFG_SRC_LSB +: 2] != sgl_pkg::SRC_ANALOG) begin
			freq_cmd_out <= 11'h000;
			freq_valid_out <= 1'b0;
		end else if (!asel_set) begin
			freq_cmd_out <= {1'b0, volt_analog_in} + {1'b0, current_analog_in};
			freq_valid_out <= 1'b1;
		end else if (asel_on) begin
			freq_cmd_out <= {1'b0, current_analog_in};
			freq_valid_out <= 1'b1;
		end else begin
			freq_cmd_out <= {1'b0, volt_analog_in};
			freq_valid_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_guard_trip_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == sgl_pkg::ST_POWERUP && settled && run_on && guard_on && !rs_on
		|=> trip_out && !drive_out && err_code_out == 8'h0D)
		else $error("guard trip not entered at powerup");
	a_auto_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == sgl_pkg::ST_POWERUP && settled && run_on && !guard_on && !rs_on
		|=> drive_out)
		else $error("no start after powerup");
	a_guard_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == sgl_pkg::ST_GUARD_TRIP && !run_on |=> !trip_out)
		else $error("guard alarm not cleared");
	a_rerun_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == sgl_pkg::ST_STOP && run_on && !uv_on && !rs_on |=> drive_out)
		else $error("run again did not start");
	a_rs_resume: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == sgl_pkg::ST_RESET_HOLD && from_guard_reg && !rs_on && run_on |=> drive_out)
		else $error("no resume after reset");
	a_uv_recheck: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == sgl_pkg::ST_RESET_HOLD && !from_guard_reg && !rs_on
		|=> state_reg == sgl_pkg::ST_POWERUP)
		else $error("guard check skipped after reset");
	a_lock_refuse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		edit_req_in && lock_in_on && !edit_is_freq_in |=> edit_refused_out && !edit_ack_out)
		else $error("edit accepted under lock");
	a_unlock_accept: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		edit_req_in && !lock_active |=> edit_ack_out && !edit_refused_out)
		else $error("edit refused without lock");
	a_asel_current: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		cfg_reg[9:8] == 2'h1 && asel_set && asel_on
		|=> freq_cmd_out == {1'b0, $past(current_analog_in)})
		else $error("current input not used");
	a_reset_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rs_on |=> !drive_out && !trip_out)
		else $error("reset did not stop drive");
endmodule : sgl_top

// ===== test/sgl_panel_model.sv
// keypad and external switch panel that drives the drive's pin inputs
// assumes the bench calls its tasks from one process, just after rising edges
`timescale 1ns/1ps
module sgl_panel_model #(
	parameter int SETTLE_WAIT = 8 // short stand-in for the operator's wait after powerup
) (
	input wire logic clk_in,
	output logic run_cmd_out,
	output logic undervolt_out,
	output logic keypad_reset_out,
	output logic [4:0] slot_level_out
);
	////////////////////////////////////////////////////////////////////////////
	// all switches open at time zero
	initial begin
		run_cmd_out = 1'b0;
		undervolt_out = 1'b0;
		keypad_reset_out = 1'b0;
		slot_level_out = 5'h00;
	end
	////////////////////////////////////////////////////////////////////////////
	// run, undervoltage and slot switches move just after an edge and then stay put; the key is let go again
	task automatic set_run(input logic v);
		@(posedge clk_in);
		run_cmd_out <= v;
	endtask : set_run
	task automatic set_uv(input logic v);
		@(posedge clk_in);
		undervolt_out <= v;
	endtask : set_uv
	task automatic set_slot(input int i, input logic v);
		@(posedge clk_in);
		slot_level_out[i] <= v;
	endtask : set_slot
	// patient operator: waits before closing run so no guard trip follows
	task automatic run_after_settle();
		repeat (SETTLE_WAIT) @(posedge clk_in);
		run_cmd_out <= 1'b1;
	endtask : run_after_settle
	// stop/reset key held for several cycles, then let go
	task automatic press_key();
		@(posedge clk_in);
		keypad_reset_out <= 1'b1;
		repeat (5) @(posedge clk_in);
		keypad_reset_out <= 1'b0;
	endtask : press_key
endmodule : sgl_panel_model

// ===== test/start_guard_lock_input_select_tb_top.sv
// self-checking bench for the start guard, edit lock and analog select block
// assumes the design answers apb in the access phase and pins settle in a few cycles
`timescale 1ns/1ps
module start_guard_lock_input_select_tb_top;
	logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic [7:0] paddr_in, err_code_out;
	logic [31:0] pwdata_in, prdata_out;
	logic run_cmd_in, undervolt_in, keypad_reset_in, edit_req_in, edit_is_freq_in;
	logic [4:0] slot_level_in;
	logic [9:0] volt_analog_in, current_analog_in;
	logic drive_out, trip_out, edit_ack_out, edit_refused_out, freq_valid_out, irq_out;
	logic [10:0] freq_cmd_out;
	int num_checks = 0; // comparisons made
	int miscompares = 0; // mismatches seen
	logic [31:0] xs_state = 32'h0000_6D29; // random state, seed 27945
	logic [31:0] rd, r;
	logic er, lvl, scope, lockb, fq, asg;
	logic [1:0] src;
	int ef, vv, cc, e, any_ref;
	int exp_q[$]; // expected refusals, oldest first
	////////////////////////////////////////////////////////////////////////////
	sgl_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .run_cmd_in(run_cmd_in), .undervolt_in(undervolt_in),
		.keypad_reset_in(keypad_reset_in), .slot_level_in(slot_level_in),
		.edit_req_in(edit_req_in), .edit_is_freq_in(edit_is_freq_in),
		.volt_analog_in(volt_analog_in), .current_analog_in(current_analog_in),
		.drive_out(drive_out), .trip_out(trip_out), .err_code_out(err_code_out),
		.edit_ack_out(edit_ack_out), .edit_refused_out(edit_refused_out),
		.freq_cmd_out(freq_cmd_out), .freq_valid_out(freq_valid_out), .irq_out(irq_out));
	sgl_panel_model panel_u (.clk_in(clk_in), .run_cmd_out(run_cmd_in),
		.undervolt_out(undervolt_in), .keypad_reset_out(keypad_reset_in),
		.slot_level_out(slot_level_in));
	////////////////////////////////////////////////////////////////////////////
	// clock at 100 MHz
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// xorshift source of random stimulus
	function automatic logic [31:0] xs();
		xs_state = xs_state ^ (xs_state << 13);
		xs_state = xs_state ^ (xs_state >> 17);
		xs_state = xs_state ^ (xs_state << 5);
		return xs_state;
	endfunction : xs
	// slot map: guard, lock, select (or none), reset, unused
	function automatic logic [31:0] slots(input logic sel);
		return {7'h00, 5'h00, sgl_pkg::FN_RESET, sel ? sgl_pkg::FN_ASEL : 5'h00,
			sgl_pkg::FN_LOCK, sgl_pkg::FN_GUARD};
	endfunction : slots
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			$display("[ERR] %s expected %0h seen %0h", nm, x, g);
			miscompares++;
		end
	endtask : chk
	// one apb transfer; answer taken at the edge where pready is high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic se);
		int n = 0;
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		// pready is read at each rising edge as it stood before that edge
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 32'h1, 32'(pready_out));
		q = prdata_out;
		se = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask : wr
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, rd, er);
		chk(nm, x, rd);
	endtask : rdchk
	// bounded wait for the drive outputs to reach a state, then compare
	task automatic wait_out(input logic d, input logic t, input logic [7:0] x);
		int n = 0;
		repeat (4) @(negedge clk_in);
		while ({drive_out, trip_out, err_code_out} !== {d, t, x} && n < 30) begin
			@(negedge clk_in);
			n++;
		end
		chk("drive", 32'(d), 32'(drive_out));
		chk("trip", 32'(t), 32'(trip_out));
		chk("err code", 32'(x), 32'(err_code_out));
	endtask : wait_out
	// reset slot pulse; motor output off while it is held
	task automatic rst_pulse();
		panel_u.set_slot(3, 1'b1);
		repeat (6) @(negedge clk_in);
		chk("hold drive", 32'h0, 32'(drive_out));
		chk("hold trip", 32'h0, 32'(trip_out));
		panel_u.set_slot(3, 1'b0);
	endtask : rst_pulse
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_in);
		chk("watchdog", 32'h0, 32'h1);
		summarize();
	end
	// main sequence
	initial begin
		{rst_n_in, psel_in, penable_in, pwrite_in, edit_req_in, edit_is_freq_in} = 6'h00;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		volt_analog_in = 10'h000;
		current_analog_in = 10'h000;
		panel_u.set_run(1'b1);
		panel_u.set_slot(0, 1'b1);
		repeat (18) @(posedge clk_in);
		rst_n_in <= 1'b1;
		wait_out(1'b1, 1'b0, sgl_pkg::ERR_NONE);
		rdchk("status run", sgl_pkg::STAT_OFS, 32'h0000_0002);
		wr(sgl_pkg::INT_MASK_OFS, 32'h1);
		wr(sgl_pkg::SLOT_OFS, slots(1'b1));
		rdchk("slot map", sgl_pkg::SLOT_OFS, slots(1'b1));
		apb(1'b0, 8'h20, 32'h0, rd, er);
		chk("unmapped err", 32'h1, 32'(er));
		chk("unmapped data", 32'h0, rd);
		rst_pulse();
		wait_out(1'b0, 1'b1, sgl_pkg::ERR_GUARD);
		rdchk("status trip", sgl_pkg::STAT_OFS, 32'h0000_0D03);
		repeat (3) @(negedge clk_in);
		chk("irq set", 32'h1, 32'(irq_out));
		rdchk("int stat", sgl_pkg::INT_STAT_OFS, 32'h1);
		wr(sgl_pkg::INT_STAT_OFS, 32'h1);
		rdchk("int clear", sgl_pkg::INT_STAT_OFS, 32'h0);
		chk("irq clear", 32'h0, 32'(irq_out));
		panel_u.set_run(1'b0);
		wait_out(1'b0, 1'b0, sgl_pkg::ERR_NONE);
		panel_u.run_after_settle();
		wait_out(1'b1, 1'b0, sgl_pkg::ERR_NONE);
		rst_pulse();
		wait_out(1'b0, 1'b1, sgl_pkg::ERR_GUARD);
		rst_pulse();
		wait_out(1'b1, 1'b0, sgl_pkg::ERR_NONE);
		rst_pulse();
		wait_out(1'b0, 1'b1, sgl_pkg::ERR_GUARD);
		panel_u.press_key();
		wait_out(1'b1, 1'b0, sgl_pkg::ERR_NONE);
		panel_u.set_uv(1'b1);
		wait_out(1'b0, 1'b1, sgl_pkg::ERR_UV);
		panel_u.set_uv(1'b0);
		rst_pulse();
		wait_out(1'b0, 1'b1, sgl_pkg::ERR_GUARD);
		panel_u.set_slot(0, 1'b0);
		rst_pulse();
		rst_pulse();
		wait_out(1'b1, 1'b0, sgl_pkg::ERR_NONE);
		wr(sgl_pkg::INT_STAT_OFS, 32'h7);
		// random edit requests against lock input, lock bit and scope
		any_ref = 0;
		for (int i = 0; i < 40; i++) begin
			r = xs();
			{fq, lockb, scope, lvl} = r[3:0];
			panel_u.set_slot(1, lvl);
			wr(sgl_pkg::CFG_OFS, {22'h0, 2'h1, 6'h00, lockb, scope});
			repeat (3) @(posedge clk_in);
			edit_req_in <= 1'b1;
			edit_is_freq_in <= fq;
			@(posedge clk_in);
			edit_req_in <= 1'b0;
			exp_q.push_back(((lvl | lockb) && !(fq && !scope)) ? 1 : 0);
			@(negedge clk_in);
			e = exp_q.pop_front();
			any_ref = any_ref | e;
			chk("edit refused", 32'(e), 32'(edit_refused_out));
			chk("edit ack", 32'(1 - e), 32'(edit_ack_out));
		end
		// random analog words, source setting and select slot
		for (int i = 0; i < 30; i++) begin
			r = xs();
			{src, lvl, asg} = r[7:4];
			vv = int'(r[17:8]);
			cc = int'(r[27:18]);
			wr(sgl_pkg::SLOT_OFS, slots(asg));
			wr(sgl_pkg::CFG_OFS, {22'h0, src, 8'h00});
			panel_u.set_slot(2, lvl);
			volt_analog_in <= r[17:8];
			current_analog_in <= r[27:18];
			repeat (6) @(negedge clk_in);
			ef = (src != 2'h1) ? 0 : (asg ? (lvl ? cc : vv) : vv + cc);
			chk("freq cmd", 32'(ef), 32'(freq_cmd_out));
			chk("freq valid", 32'(src == 2'h1), 32'(freq_valid_out));
		end
		// refusals are latched but masked until the mask admits them
		rdchk("int refuse", sgl_pkg::INT_STAT_OFS, 32'(any_ref << 2));
		chk("irq masked", 32'h0, 32'(irq_out));
		wr(sgl_pkg::INT_MASK_OFS, 32'h4);
		repeat (3) @(negedge clk_in);
		chk("irq unmasked", 32'(any_ref), 32'(irq_out));
		summarize();
	end
endmodule : start_guard_lock_input_select_tb_top
